// ---- design/rtc_wake_top.sv ----
// Battery-domain BCD calendar clock with alarm, periodic and wake logic
// Contract
// R01: Time and settings survive core power-off; control, pending write lost.
// R02: Alarm, periodic or wake-pin events can wake the device from idle.
// R03: Alarm or periodic event can be driven out on the wake pin.
// R04: Calendar covers one hundred years, ending at year 2099.
// R05: Counts seconds to year with weekday and leap-year compensation.
// R06: All time, calendar and alarm values are BCD, hours 24-hour. The millisecond count is kept in binary here.
// R07: Alarm matches on second, minute, hour, day or week.
// R08: Periodic event every millisecond, second, minute, hour or day.
// R09: Alarm and periodic sources share one interrupt line.
// R10: Crystal at 32.768 kHz, millisecond drift correction for calibration.
// R11: Processor clock must run at least three times the crystal rate.
// R12: Register writes take effect two crystal cycles after issue.
// R13: Register writes ignored while the oscillator is disabled.
// R14: Own power-on reset clears the block's registers.
// R15: Chip reset and core supply-good never reset the flip-flops.
// R16: Other party raises wake pin one crystal period to leave power-down.
// R17: Power-down bits turn off the core regulator; supply-good isolates.
// R18: Supply-good rising ends isolation and allows processor access.
// R19: While supply-good is low, bus ignored and core outputs inactive.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`include "rtc_wake_regs.svh"
module rtc_wake_top
  import rtc_wake_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic RTC_XTAL_IN,
  input wire logic OSC_EN_IN,
  input wire logic PWR_GOOD_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  output logic IRQ_OUT,
  output logic WAKE_REQ_OUT,
  input wire logic WAKE_IN,
  output logic WAKE_OUT,
  output logic WAKE_OE_OUT,
  output logic REG_OFF_OUT
);

  //////////////////////////////////////////////////////////////////////
  // BCD helpers
  function automatic logic [7:0] bcd_next(input logic [7:0] v,
    input logic [7:0] last, input logic [7:0] first);
    logic [7:0] r;
    r = v + 8'h01;
    if (v == last)
      r = first;
    else if (v[3:0] == 4'h9)
      r = {v[7:4] + 4'h1, 4'h0};
    return r;
  endfunction : bcd_next

  function automatic logic [7:0] month_last(input logic [7:0] m,
    input logic [7:0] y);
    logic leap;
    logic [7:0] r;
    // Years 00..99 stand for 2000..2099, so every fourth year is leap
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    r = 8'h31;
    if (m == 8'h02)
      r = leap ? 8'h29 : 8'h28;
    else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
      r = 8'h30;
    return r;
  endfunction : month_last

  //////////////////////////////////////////////////////////////////////
  rtc_state_s q;
  rtc_state_s d;
  logic tick, ms_tick, sec_tick, min_tick, hr_tick, day_tick;
  logic mon_tick, yr_tick, alarm_hit, period_hit, wake_rise;
  logic apply, take_wr;
  logic [1:0] step;
  logic [15:0] frac_sum;
  logic [10:0] ms_sum;
  logic [7:0] last_day;
  logic [2:0] ev;
  logic [2:0] pending_core;

  always_comb
  begin
    d = q;
    // Pin-side inputs pass two flops before any logic reads them
    d.xs1 = RTC_XTAL_IN;
    d.xs2 = q.xs1;
    d.xs3 = q.xs2;
    d.pg1 = PWR_GOOD_IN;
    d.pg2 = q.pg1;
    d.wk1 = WAKE_IN;
    d.wk2 = q.wk1;
    d.wk3 = q.wk2;
    d.oe1 = OSC_EN_IN;
    d.oe2 = q.oe1;
    // R10: crystal edge is the time base, halted with the oscillator
    tick = q.xs2 & ~q.xs3 & q.oe2;
    ms_tick = 1'b0;
    min_tick = 1'b0;
    hr_tick = 1'b0;
    day_tick = 1'b0;
    mon_tick = 1'b0;
    yr_tick = 1'b0;
    step = 2'd1;
    frac_sum = q.frac + `RTC_MS_STEP;
    if (tick)
    begin
      if (frac_sum >= `RTC_XTAL_HZ)
      begin
        ms_tick = 1'b1;
        d.frac = frac_sum - `RTC_XTAL_HZ;
      end
      else
        d.frac = frac_sum;
    end
    // R10: spread a signed millisecond correction over coming ticks
    if (ms_tick && q.corr != 7'd0)
    begin
      d.corr = q.corr - 7'd1;
      step = q.corr_neg ? 2'd0 : 2'd2;
    end
    ms_sum = {1'b0, q.ms} + {9'd0, ms_tick ? step : 2'd0};
    sec_tick = ms_sum >= `RTC_MS_PER_S;
    d.ms = sec_tick ? 10'(ms_sum - `RTC_MS_PER_S) : ms_sum[9:0];
    // R05 R06: BCD carry chain, hours in 24-hour form
    if (sec_tick)
    begin
      d.tod.sec = bcd_next(q.tod.sec, `RTC_LAST_SEC, 8'h00);
      min_tick = q.tod.sec == `RTC_LAST_SEC;
    end
    if (min_tick)
    begin
      d.tod.min = bcd_next(q.tod.min, `RTC_LAST_SEC, 8'h00);
      hr_tick = q.tod.min == `RTC_LAST_SEC;
      d.corr = q.drift[6:0];
      d.corr_neg = q.drift[7];
    end
    if (hr_tick)
    begin
      d.tod.hr = bcd_next(q.tod.hr, `RTC_LAST_HOUR, 8'h00);
      day_tick = q.tod.hr == `RTC_LAST_HOUR;
    end
    // R05: month length follows the leap year
    last_day = month_last(q.cal.mon, q.cal.year);
    if (day_tick)
    begin
      d.cal.wday = (q.cal.wday == `RTC_LAST_WDAY) ? 3'h0
                                                  : q.cal.wday + 3'h1;
      d.cal.date = bcd_next(q.cal.date, last_day, 8'h01);
      mon_tick = q.cal.date == last_day;
    end
    if (mon_tick)
    begin
      d.cal.mon = bcd_next(q.cal.mon, `RTC_LAST_MON, 8'h01);
      yr_tick = q.cal.mon == `RTC_LAST_MON;
    end
    // R04: year 99 (2099) rolls back to 00
    if (yr_tick)
      d.cal.year = bcd_next(q.cal.year, `RTC_LAST_YEAR, 8'h00);
    // R07: compare the new time against the alarm fields
    alarm_hit = 1'b0;
    if (sec_tick)
    begin
      unique case (alarm_sel_e'(q.alarm_sel))
        AL_SEC: alarm_hit = d.tod.sec == q.atod.sec;
        AL_MIN: alarm_hit = d.tod[15:0] == q.atod[15:0];
        AL_HOUR: alarm_hit = d.tod == q.atod;
        AL_DAY: alarm_hit = d.tod == q.atod && d.cal.date == q.adate;
        AL_WEEK: alarm_hit = d.tod == q.atod && d.cal.wday == q.awday;
        default: alarm_hit = 1'b0;
      endcase
    end
    // R08: periodic event source selection
    unique case (period_sel_e'(q.per_sel))
      PR_MS: period_hit = ms_tick;
      PR_SEC: period_hit = sec_tick;
      PR_MIN: period_hit = min_tick;
      PR_HOUR: period_hit = hr_tick;
      PR_DAY: period_hit = day_tick;
      default: period_hit = 1'b0;
    endcase
    // R02: own drive on the pin is not taken as an external wake
    wake_rise = q.wk2 & ~q.wk3 & ~q.wake_oe;
    ev = {wake_rise, period_hit, alarm_hit};
    // R18 R19 R13: writes taken only with supply good and oscillator running, reads with supply good
    take_wr = WR_IN & q.pg2 & q.oe2;
    // R12: second crystal edge after the write makes it visible
    apply = q.pend_v & tick & (q.pend_cnt == `RTC_WR_DELAY - 2'd1);
    if (q.pend_v && tick)
      d.pend_cnt = q.pend_cnt + 2'd1;
    if (apply)
    begin
      d.pend_v = 1'b0;
      unique case (q.pend_addr)
        `RTC_IDX_CTRL: d.ctrl_en = q.pend_data[0];
        `RTC_IDX_TIME: d.tod = q.pend_data[23:0];
        `RTC_IDX_DATE: d.cal = q.pend_data[26:0];
        `RTC_IDX_ATIME: d.atod = q.pend_data[23:0];
        `RTC_IDX_ADATE:
        begin
          d.awday = q.pend_data[26:24];
          d.adate = q.pend_data[7:0];
        end
        `RTC_IDX_CFG:
        begin
          d.alarm_sel = q.pend_data[2:0];
          d.per_sel = q.pend_data[5:3];
          d.wake_out_en = q.pend_data[`RTC_CFG_WAKEOUT];
        end
        `RTC_IDX_STATUS: d.status = q.status & ~q.pend_data[2:0];
        `RTC_IDX_MASK: d.mask = q.pend_data[2:0];
        `RTC_IDX_DRIFT: d.drift = q.pend_data[7:0];
        `RTC_IDX_PMGT:
        begin
          d.pd_reg = q.pend_data[`RTC_PM_REG];
          d.pd_bg = q.pend_data[`RTC_PM_BG];
        end
        `RTC_IDX_SCRATCH: d.scratch = q.pend_data;
        `RTC_IDX_MSEC: d.ms = q.pend_data[9:0];
        default: d.pend_v = 1'b0;
      endcase
    end
    // Set wins over a write-one clear in the same cycle
    d.status = d.status | ev;
    // R16 R17: external wake pulse cancels the power-down request
    if (wake_rise)
    begin
      d.pd_reg = 1'b0;
      d.pd_bg = 1'b0;
    end
    // A newer write replaces one still waiting for the crystal
    if (take_wr)
    begin
      d.pend_v = 1'b1;
      d.pend_cnt = 2'd0;
      d.pend_addr = ADDR_IN;
      d.pend_data = WDATA_IN;
    end
    d.rdata = 32'h0000_0000;
    if (RD_IN && q.pg2)
    begin
      unique case (ADDR_IN)
        `RTC_IDX_CTRL: d.rdata = {31'h0000_0000, q.ctrl_en};
        `RTC_IDX_TIME: d.rdata = {8'h00, q.tod};
        `RTC_IDX_DATE: d.rdata = {5'h00, q.cal};
        `RTC_IDX_ATIME: d.rdata = {8'h00, q.atod};
        `RTC_IDX_ADATE: d.rdata = {5'h00, q.awday, 16'h0000, q.adate};
        `RTC_IDX_CFG: d.rdata = {25'h000_0000, q.wake_out_en, q.per_sel,
                                 q.alarm_sel};
        `RTC_IDX_STATUS: d.rdata = {23'h00_0000, q.pend_v, 5'h00,
                                    q.status};
        `RTC_IDX_MASK: d.rdata = {29'h0000_0000, q.mask};
        `RTC_IDX_DRIFT: d.rdata = {24'h00_0000, q.drift};
        `RTC_IDX_PMGT: d.rdata = {30'h0000_0000, q.pd_bg, q.pd_reg};
        `RTC_IDX_SCRATCH: d.rdata = q.scratch;
        `RTC_IDX_MSEC: d.rdata = {22'h00_0000, q.ms};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    // R01: core-side control and waiting update lost with core power
    if (!q.pg2)
    begin
      d.ctrl_en = 1'b0;
      d.pend_v = 1'b0;
    end
    pending_core = q.status & q.mask;
    // R09: one interrupt line for alarm and periodic sources
    d.irq = q.pg2 & q.ctrl_en & (|pending_core[1:0]);
    // R02: idle wake for any unmasked event, core side only
    d.wake_req = q.pg2 & (|pending_core);
    // R03: drive wake pin high to call for power restore
    d.wake_oe = q.wake_out_en & (|pending_core[1:0]);
    // R17: either power-down bit switches the core regulator off
    d.reg_off = q.pd_reg | q.pd_bg;
  end

  //////////////////////////////////////////////////////////////////////
  // R14 R15: only the block's own power-on reset clears state
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      q <= '0;
      q.cal.date <= `RTC_RST_DATE;
      q.cal.mon <= `RTC_RST_MON;
      q.adate <= `RTC_RST_DATE;
    end
    else
      q <= d;
  end

  // Pin level and enable share one flop, so the pin is only driven high
  assign RDATA_OUT = q.rdata;
  assign IRQ_OUT = q.irq;
  assign WAKE_REQ_OUT = q.wake_req;
  assign WAKE_OUT = q.wake_oe;
  assign WAKE_OE_OUT = q.wake_oe;
  assign REG_OFF_OUT = q.reg_off;

  //////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_write_taken;
    WR_IN && q.pg2 && q.oe2;
  endsequence
  sequence s_no_tick_after;
    !tick [*2];
  endsequence

  chk_write_delay: assert property (@(posedge CORE_CLK_IN) // R12
    disable iff (!RST_N_IN) s_write_taken ##1 s_no_tick_after
    |-> q.pend_v)
    else $error("write applied before two crystal edges");
  chk_osc_off_write: assert property (@(posedge CORE_CLK_IN) // R13
    disable iff (!RST_N_IN) WR_IN && !q.oe2 && !q.pend_v |=> !q.pend_v)
    else $error("write taken with oscillator off");
  chk_pgood_isolate: assert property (@(posedge CORE_CLK_IN) // R19
    disable iff (!RST_N_IN) !q.pg2 |=> !IRQ_OUT && !WAKE_REQ_OUT
    && RDATA_OUT == 32'h0000_0000)
    else $error("core outputs active without supply good");
  chk_pgood_ctrl: assert property (@(posedge CORE_CLK_IN) // R01
    disable iff (!RST_N_IN) !q.pg2 |=> !q.ctrl_en && !q.pend_v)
    else $error("control survived core power loss");
  chk_year_wrap: assert property (@(posedge CORE_CLK_IN) // R04
    disable iff (!RST_N_IN) yr_tick && q.cal.year == 8'h99 && !apply
    |=> q.cal.year == 8'h00 && q.cal.mon == 8'h01)
    else $error("year 2099 did not roll over");
  chk_leap_feb: assert property (@(posedge CORE_CLK_IN) // R05
    disable iff (!RST_N_IN) day_tick && !apply && q.cal.mon == 8'h02
    && q.cal.date == 8'h28 && q.cal.year == 8'h24 |=> q.cal.date == 8'h29)
    else $error("leap day skipped");
  chk_hour_wrap: assert property (@(posedge CORE_CLK_IN) // R06
    disable iff (!RST_N_IN) hr_tick && !apply && q.tod.hr == 8'h23
    |=> q.tod.hr == 8'h00)
    else $error("hour did not wrap at 23");
  chk_alarm_flag: assert property (@(posedge CORE_CLK_IN) // R07
    disable iff (!RST_N_IN) alarm_hit |=> q.status[`RTC_ST_ALARM])
    else $error("alarm match lost");
  chk_irq_combine: assert property (@(posedge CORE_CLK_IN) // R09
    disable iff (!RST_N_IN) q.pg2 && q.ctrl_en
    && |(q.status[1:0] & q.mask[1:0]) |=> IRQ_OUT)
    else $error("interrupt not raised");
  chk_wake_drive: assert property (@(posedge CORE_CLK_IN) // R03
    disable iff (!RST_N_IN) q.wake_out_en && |(q.status[1:0] & q.mask[1:0])
    |=> WAKE_OE_OUT && WAKE_OUT)
    else $error("wake pin not driven");
  chk_reg_off: assert property (@(posedge CORE_CLK_IN) // R17
    disable iff (!RST_N_IN) q.pd_reg || q.pd_bg |=> REG_OFF_OUT)
    else $error("regulator not switched off");
  chk_period_ms: assert property (@(posedge CORE_CLK_IN) // R08
    disable iff (!RST_N_IN) q.per_sel == 3'h1 && ms_tick
    |=> q.status[`RTC_ST_PERIOD])
    else $error("periodic event lost");
  chk_pgood_access: assert property (@(posedge CORE_CLK_IN) // R18
    disable iff (!RST_N_IN) s_write_taken |=> q.pend_v)
    else $error("write refused with supply good");
  chk_wake_event: assert property (@(posedge CORE_CLK_IN) // R02
    disable iff (!RST_N_IN) wake_rise
    |=> q.status[`RTC_ST_WAKEPIN] && !q.pd_reg && !q.pd_bg)
    else $error("wake pin rise not taken");
  chk_irq_enable: assert property (@(posedge CORE_CLK_IN) // R09
    disable iff (!RST_N_IN) !q.ctrl_en |=> !IRQ_OUT)
    else $error("interrupt raised while disabled");
  chk_wake_quiet: assert property (@(posedge CORE_CLK_IN) // R03
    disable iff (!RST_N_IN) !q.wake_out_en |=> !WAKE_OE_OUT)
    else $error("wake pin driven while disabled");
  chk_min_carry: assert property (@(posedge CORE_CLK_IN) // R05
    disable iff (!RST_N_IN) sec_tick && !apply && q.tod.sec == 8'h59
    |=> q.tod.sec == 8'h00)
    else $error("seconds did not wrap at 59");
  chk_osc_halt: assert property (@(posedge CORE_CLK_IN) // R10
    disable iff (!RST_N_IN) !q.oe2 |=> $stable(q.ms))
    else $error("time counted with oscillator off");

endmodule : rtc_wake_top

// ---- design/rtc_wake_regs.svh ----
// Register map, field positions, reset values and timing counts
`ifndef RTC_WAKE_REGS_SVH
`define RTC_WAKE_REGS_SVH
`define RTC_IDX_CTRL 4'h0
`define RTC_IDX_TIME 4'h1
`define RTC_IDX_DATE 4'h2
`define RTC_IDX_ATIME 4'h3
`define RTC_IDX_ADATE 4'h4
`define RTC_IDX_CFG 4'h5
`define RTC_IDX_STATUS 4'h6
`define RTC_IDX_MASK 4'h7
`define RTC_IDX_DRIFT 4'h8
`define RTC_IDX_PMGT 4'h9
`define RTC_IDX_SCRATCH 4'hA
`define RTC_IDX_MSEC 4'hB
`define RTC_ST_ALARM 0
`define RTC_ST_PERIOD 1
`define RTC_ST_WAKEPIN 2
`define RTC_ST_BUSY 8
`define RTC_CFG_WAKEOUT 6
`define RTC_PM_REG 0
`define RTC_PM_BG 1
`define RTC_XTAL_HZ 16'h8000
`define RTC_MS_PER_S 11'h03E8
`define RTC_MS_STEP 16'h03E8
`define RTC_WR_DELAY 2'h2
`define RTC_RST_DATE 8'h01
`define RTC_RST_MON 8'h01
`define RTC_LAST_SEC 8'h59
`define RTC_LAST_HOUR 8'h23
`define RTC_LAST_MON 8'h12
`define RTC_LAST_YEAR 8'h99
`define RTC_LAST_WDAY 3'h6
`endif

// ---- design/rtc_wake_pkg.sv ----
// Types shared by the calendar clock block
package rtc_wake_pkg;
  typedef enum logic [2:0] {AL_OFF, AL_SEC, AL_MIN, AL_HOUR, AL_DAY,
    AL_WEEK} alarm_sel_e;
  typedef enum logic [2:0] {PR_OFF, PR_MS, PR_SEC, PR_MIN, PR_HOUR,
    PR_DAY} period_sel_e;
  typedef struct packed {
    logic [7:0] hr;
    logic [7:0] min;
    logic [7:0] sec;
  } tod_s;
  typedef struct packed {
    logic [2:0] wday;
    logic [7:0] year;
    logic [7:0] mon;
    logic [7:0] date;
  } cal_s;
  typedef struct packed {
    logic xs1, xs2, xs3, pg1, pg2, wk1, wk2, wk3, oe1, oe2;
    logic [15:0] frac;
    logic [9:0] ms;
    tod_s tod;
    cal_s cal;
    tod_s atod;
    logic [2:0] awday;
    logic [7:0] adate;
    logic ctrl_en;
    logic [2:0] alarm_sel;
    logic [2:0] per_sel;
    logic wake_out_en;
    logic [7:0] drift;
    logic [6:0] corr;
    logic corr_neg;
    logic [2:0] status;
    logic [2:0] mask;
    logic pd_reg;
    logic pd_bg;
    logic [31:0] scratch;
    logic pend_v;
    logic [1:0] pend_cnt;
    logic [3:0] pend_addr;
    logic [31:0] pend_data;
    logic [31:0] rdata;
    logic irq;
    logic wake_req;
    logic wake_oe;
    logic reg_off;
  } rtc_state_s;
endpackage : rtc_wake_pkg

// ---- verif/rtc_far_side_model.sv ----
// Crystal, core regulator and wake-pin driver beside the clock block
module rtc_far_side_model #(
  parameter int XTAL_HALF_NS = 15259,
  parameter int RAMP_CYCLES = 40
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reg_off_in,
  input wire logic wake_go_in,
  output logic xtal_out,
  output logic pwr_good_out,
  output logic wake_drive_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int ramp_q;
  ////////////////////////////////////////
  // crystal well below core
  // Odd start offset keeps its phase unrelated to the core clock
  initial
  begin
    xtal_out = 1'b0;
    #7;
    forever #(XTAL_HALF_NS) xtal_out = ~xtal_out;
  end
  // supply-good follows regulator
  // Regulator ramps for a while before supply-good returns
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pwr_good_out <= 1'b1;
      ramp_q <= 0;
    end
    else if (reg_off_in)
    begin
      pwr_good_out <= 1'b0;
      ramp_q <= 0;
    end
    else if (!pwr_good_out)
    begin
      if (ramp_q == RAMP_CYCLES)
        pwr_good_out <= 1'b1;
      else
        ramp_q <= ramp_q + 1;
    end
  end
  // wake pulse two crystal periods
  // One process owns the pin so it has a single driver
  initial
  begin
    wake_drive_out = 1'b0;
    forever
    begin
      @(posedge wake_go_in);
      @(posedge clk_in);
      wake_drive_out <= 1'b1;
      #(4 * XTAL_HALF_NS);
      @(posedge clk_in);
      wake_drive_out <= 1'b0;
    end
  end
endmodule : rtc_far_side_model

// ---- verif/rtc_calendar_wake_domain_bench.sv ----
// Self-checking bench for the calendar clock block
`include "rtc_wake_regs.svh"
module rtc_calendar_wake_domain_bench
  import rtc_wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, osc_en, wr, rd, irq, wake_req, wake_out, wake_oe;
  logic reg_off, xtal, pwr_good, wake_drive, wake_go;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  wire wake_pin;
  int errors = 0;
  int samples_checked = 0;
  // Pin is pulled low when nobody drives it
  assign wake_pin = (wake_oe & wake_out) | wake_drive;
  rtc_wake_top dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
    .RTC_XTAL_IN(xtal), .OSC_EN_IN(osc_en), .PWR_GOOD_IN(pwr_good),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdata), .IRQ_OUT(irq), .WAKE_REQ_OUT(wake_req),
    .WAKE_IN(wake_pin), .WAKE_OUT(wake_out), .WAKE_OE_OUT(wake_oe),
    .REG_OFF_OUT(reg_off));
  // Crystal sped up to one eighth of the core rate to keep runs short
  rtc_far_side_model #(.XTAL_HALF_NS(100), .RAMP_CYCLES(40)) far (
    .clk_in(clk), .rst_n_in(rst_n), .reg_off_in(reg_off),
    .wake_go_in(wake_go), .xtal_out(xtal), .pwr_good_out(pwr_good),
    .wake_drive_out(wake_drive));
  ////////////////////////////////////////
  task give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task chk32(input logic [31:0] got, input logic [31:0] exp, string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk32
  task chk1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %b", $time, what, got);
    end
  endtask : chk1
  task settle();
    repeat (3) @(posedge xtal);
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task wr_reg(input logic [3:0] idx, input logic [31:0] d, input bit s);
    @(posedge clk);
    wr <= 1'b1;
    addr <= idx;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (s)
      settle();
  endtask : wr_reg
  task rd_reg(input logic [3:0] idx, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= idx;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk32(rdata, exp, "read data");
    @(posedge clk);
    #1;
    chk32(rdata, 32'h0000_0000, "read data after its cycle");
  endtask : rd_reg
  task wait_bit(input int sel, input logic val);
    int n;
    logic b;
    n = 0;
    b = ~val;
    while (b !== val && n < 3000)
    begin
      @(posedge clk);
      #1;
      b = sel == 0 ? irq : sel == 1 ? wake_oe : sel == 2 ? reg_off : pwr_good;
      n++;
    end
    if (b !== val)
    begin
      errors++;
      $display("mismatch at %0t: wait %0d ran out", $time, sel);
      give_verdict();
    end
  endtask : wait_bit
  ////////////////////////////////////////
  task t_reset();
    rd_reg(`RTC_IDX_TIME, 32'h0000_0000);
    rd_reg(`RTC_IDX_DATE, 32'h0000_0101);
    rd_reg(`RTC_IDX_ADATE, 32'h0000_0001);
    rd_reg(`RTC_IDX_STATUS, 32'h0000_0000);
    wr_reg(4'hF, 32'hFFFF_FFFF, 1);
    rd_reg(4'hF, 32'h0000_0000);
  endtask : t_reset
  task t_delay();
    wr_reg(`RTC_IDX_SCRATCH, 32'hC0DE_0042, 0);
    rd_reg(`RTC_IDX_STATUS, 32'h0000_0100);
    rd_reg(`RTC_IDX_SCRATCH, 32'h0000_0000);
    settle();
    rd_reg(`RTC_IDX_SCRATCH, 32'hC0DE_0042);
  endtask : t_delay
  task t_osc_off();
    @(posedge clk);
    osc_en <= 1'b0;
    repeat (4) @(posedge clk);
    wr_reg(`RTC_IDX_SCRATCH, 32'h5555_AAAA, 1);
    @(posedge clk);
    osc_en <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(`RTC_IDX_SCRATCH, 32'hC0DE_0042);
  endtask : t_osc_off
  task t_irq();
    wr_reg(`RTC_IDX_CFG, 32'h0000_0008, 1);
    wr_reg(`RTC_IDX_MASK, 32'h0000_0002, 1);
    wr_reg(`RTC_IDX_CTRL, 32'h0000_0001, 1);
    wait_bit(0, 1'b1);
    chk1(wake_req, 1'b1, "idle wake");
    rd_reg(`RTC_IDX_STATUS, 32'h0000_0002);
    wr_reg(`RTC_IDX_MASK, 32'h0000_0000, 1);
    chk1(irq, 1'b0, "masked irq");
    chk1(wake_req, 1'b0, "masked wake");
    wr_reg(`RTC_IDX_MASK, 32'h0000_0002, 1);
    chk1(irq, 1'b1, "unmasked irq");
    wr_reg(`RTC_IDX_CTRL, 32'h0000_0000, 1);
    chk1(irq, 1'b0, "irq disabled");
    chk1(wake_req, 1'b1, "wake without irq");
    wr_reg(`RTC_IDX_CFG, 32'h0000_0048, 1);
    wait_bit(1, 1'b1);
    chk1(wake_out, 1'b1, "wake pin level");
    wr_reg(`RTC_IDX_CFG, 32'h0000_0000, 1);
    wr_reg(`RTC_IDX_STATUS, 32'h0000_0007, 1);
    rd_reg(`RTC_IDX_STATUS, 32'h0000_0000);
    chk1(wake_oe, 1'b0, "wake pin released");
    chk1(wake_req, 1'b0, "wake cleared");
  endtask : t_irq
  task roll_midnight(input logic [31:0] date, input logic [31:0] cfg);
    wr_reg(`RTC_IDX_DATE, date, 1);
    wr_reg(`RTC_IDX_TIME, 32'h0023_5959, 1);
    wr_reg(`RTC_IDX_CFG, cfg, 1);
    // Last millisecond of the day, so the next one rolls everything
    wr_reg(`RTC_IDX_MSEC, 32'h0000_03E7, 1);
    repeat (40) @(posedge xtal);
  endtask : roll_midnight
  task t_year_end();
    roll_midnight(32'h0699_1231, 32'h0000_002C);
    rd_reg(`RTC_IDX_TIME, 32'h0000_0000);
    rd_reg(`RTC_IDX_DATE, 32'h0000_0101);
    rd_reg(`RTC_IDX_STATUS, 32'h0000_0003);
    chk1(wake_req, 1'b1, "periodic wake");
    wr_reg(`RTC_IDX_STATUS, 32'h0000_0007, 1);
  endtask : t_year_end
  task t_leap_day();
    roll_midnight(32'h0324_0228, 32'h0000_0023);
    rd_reg(`RTC_IDX_TIME, 32'h0000_0000);
    rd_reg(`RTC_IDX_DATE, 32'h0424_0229);
    rd_reg(`RTC_IDX_STATUS, 32'h0000_0003);
    wr_reg(`RTC_IDX_CFG, 32'h0000_0000, 1);
    wr_reg(`RTC_IDX_STATUS, 32'h0000_0007, 1);
    rd_reg(`RTC_IDX_STATUS, 32'h0000_0000);
  endtask : t_leap_day
  task t_power();
    wr_reg(`RTC_IDX_SCRATCH, 32'h1234_5678, 1);
    wr_reg(`RTC_IDX_CTRL, 32'h0000_0001, 1);
    wr_reg(`RTC_IDX_PMGT, 32'h0000_0001, 1);
    chk1(reg_off, 1'b1, "regulator off");
    wait_bit(3, 1'b0);
    repeat (4) @(posedge clk);
    chk1(irq, 1'b0, "isolated irq");
    rd_reg(`RTC_IDX_SCRATCH, 32'h0000_0000);
    wr_reg(`RTC_IDX_SCRATCH, 32'hFFFF_0000, 1);
    @(posedge clk);
    wake_go <= 1'b1;
    @(posedge clk);
    wake_go <= 1'b0;
    wait_bit(2, 1'b0);
    wait_bit(3, 1'b1);
    repeat (4) @(posedge clk);
    rd_reg(`RTC_IDX_SCRATCH, 32'h1234_5678);
    rd_reg(`RTC_IDX_CTRL, 32'h0000_0000);
    rd_reg(`RTC_IDX_STATUS, 32'h0000_0004);
    rd_reg(`RTC_IDX_PMGT, 32'h0000_0000);
  endtask : t_power
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("mismatch at %0t: run too long", $time);
    give_verdict();
  end
  initial
  begin
    rst_n = 1'b0;
    osc_en = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    wake_go = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_delay();
    t_osc_off();
    t_irq();
    t_year_end();
    t_leap_day();
    t_power();
    give_verdict();
  end
endmodule : rtc_calendar_wake_domain_bench
